// ==== gptu_pkg.sv ====
// Package with constants and types of the general purpose timer unit
package gptu_pkg;

  localparam int GPTU_W = 16;
  localparam int GPTU_NT = 5;

  // Timer indices
  localparam int IX_AUX_A = 0;
  localparam int IX_CORE = 1;
  localparam int IX_AUX_B = 2;
  localparam int IX_SAUX = 3;
  localparam int IX_SMAIN = 4;
  localparam int M1_COUNT = 3;

  // Finest count periods and derived base dividers
  localparam int CLK_PERIOD_NS = 50;
  localparam int M1_RES_NS = 400;
  localparam int M2_RES_NS = 200;
  localparam int M1_DIV = M1_RES_NS / CLK_PERIOD_NS;
  localparam int M2_DIV = M2_RES_NS / CLK_PERIOD_NS;
  localparam logic [3:0] M1_DIV_LAST = 4'(M1_DIV - 1);
  localparam logic [3:0] M2_DIV_LAST = 4'(M2_DIV - 1);

  // Reset values and counter maximum
  localparam logic [15:0] GPTU_VAL_RST = 16'h0000;
  localparam logic [15:0] GPTU_VAL_MAX = 16'hFFFF;
  localparam logic [3:0] GPTU_BASE_RST = 4'h0;
  localparam logic [6:0] GPTU_SCALE_RST = 7'h00;

  // Auxiliary timer functions
  localparam logic [1:0] AUXF_NORMAL = 2'h0;
  localparam logic [1:0] AUXF_CAPTURE = 2'h1;
  localparam logic [1:0] AUXF_RELOAD = 2'h2;

  // Reload triggers
  localparam logic [1:0] RLD_PIN = 2'h1;
  localparam logic [1:0] RLD_LATCH_RISE = 2'h2;
  localparam logic [1:0] RLD_LATCH_FALL = 2'h3;

  typedef enum logic [3:0] {
    GPTU_TIMER = 4'h1,
    GPTU_GATED = 4'h2,
    GPTU_COUNTER = 4'h4,
    GPTU_INCR = 4'h8
  } gptu_mode_e;

  typedef struct packed {
    logic cap;
    logic [4:0] dir;
    logic [4:0] cnt;
  } gptu_pins_s;

  typedef struct packed {
    logic [2:0] cap;
    logic [4:0] ovf;
  } gptu_flags_s;

  localparam gptu_pins_s GPTU_PINS_RST = 11'h000;
  localparam gptu_flags_s GPTU_FLAGS_RST = 8'h00;

endpackage

// ==== gptu_top.sv ====
// Five timer general purpose timer unit, both modules
// Behaviour
// - Five 16-bit timers, chainable within module
// - First module modes: timer, gated, counter, encoder
// - Prescaled timer mode, finest 400 ns
// - Counter mode counts count-pin edges
// - Gated mode counts while gate pin high
// - Software direction, optionally flipped by pin
// - Encoder tracks decoded into count and direction
// - Core and aux B latches toggle on wrap
// - Aux in capture or reload stops counting
// - Aux capture latches core on pin event
// - Aux reload loads core on pin/latch edge
// - Opposite latch edges alternate two reloads
// - Second module two timers, 200 ns finest
// - Second module prescaled or external clocking
// - Second main latch toggles, clocks second aux
// - Second main wrap exported, reloads from register
// - Capture register takes second aux, optional clear
// - Capture also by core input pin transitions
`timescale 1ns/1ns
module gptu_top
  import gptu_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] CNT_IN,
  input wire logic [4:0] DIR_IN,
  input wire logic CAPTURE_PIN,
  input gptu_mode_e MODE [GPTU_NT],
  input wire logic [2:0] PRESCALE [GPTU_NT],
  input wire logic [1:0] EDGE_SEL [GPTU_NT],
  input wire logic [4:0] RUN,
  input wire logic [4:0] DIR_DOWN,
  input wire logic [4:0] DIR_PIN_EN,
  input wire logic [2:0] CHAIN_LATCH,
  input wire logic [1:0] AUX_FUNC [2],
  input wire logic [1:0] RELOAD_TRIG [2],
  input wire logic SEC_RELOAD_EN,
  input wire logic [2:0] CAP_SRC,
  input wire logic [1:0] CAP_EDGE,
  input wire logic CAP_CLEAR,
  input wire logic [4:0] LOAD_EN,
  input wire logic CAPREG_LOAD,
  input wire logic [15:0] LOAD_VAL,
  input wire logic [7:0] FLAG_CLR,
  output logic [15:0] TIMER_VAL [GPTU_NT],
  output logic [15:0] CAPREG_VAL,
  output logic CORE_TOGGLE_OUT,
  output logic AUX_B_TOGGLE_OUT,
  output logic SEC_MAIN_TOGGLE_OUT,
  output logic SEC_MAIN_OVF,
  output gptu_flags_s EVENT_FLAGS
);

  gptu_pins_s s1_r, s2_r, s3_r;
  logic [3:0] b1_r, b1_nxt, b2_r, b2_nxt;
  logic [6:0] sc1_r, sc1_nxt, sc2_r, sc2_nxt;
  logic b1_tick, b2_tick;
  logic [15:0] val_r [GPTU_NT];
  logic [15:0] val_nxt [GPTU_NT];
  logic [15:0] capreg_r, capreg_nxt;
  logic core_latch_r, core_latch_nxt, auxb_latch_r, auxb_latch_nxt;
  logic smain_latch_r, smain_latch_nxt, smain_ovf_r, smain_ovf_nxt;
  gptu_flags_s flags_r, flags_nxt;
  logic [4:0] tick, down, ovf, pin_evt;
  logic [4:0] cnt_rise, cnt_fall, dir_rise, dir_fall;
  logic [1:0] cap_aux, rld_aux;
  logic capreg_evt, cap_rise, cap_fall;

  // Pin synchronisers and edge detectors
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s1_r <= GPTU_PINS_RST;
      s2_r <= GPTU_PINS_RST;
      s3_r <= GPTU_PINS_RST;
    end
    else
    begin
      s1_r <= {CAPTURE_PIN, DIR_IN, CNT_IN};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign cnt_rise = s2_r.cnt & ~s3_r.cnt;
  assign cnt_fall = ~s2_r.cnt & s3_r.cnt;
  assign dir_rise = s2_r.dir & ~s3_r.dir;
  assign dir_fall = ~s2_r.dir & s3_r.dir;
  assign cap_rise = s2_r.cap & ~s3_r.cap;
  assign cap_fall = ~s2_r.cap & s3_r.cap;

  // Base dividers of both modules
  assign b1_tick = (b1_r == M1_DIV_LAST);
  assign b2_tick = (b2_r == M2_DIV_LAST);

  always_comb
  begin
    b1_nxt = b1_tick ? GPTU_BASE_RST : b1_r + 4'h1;
    b2_nxt = b2_tick ? GPTU_BASE_RST : b2_r + 4'h1;
    sc1_nxt = b1_tick ? sc1_r + 7'h01 : sc1_r;
    sc2_nxt = b2_tick ? sc2_r + 7'h01 : sc2_r;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      b1_r <= GPTU_BASE_RST;
      b2_r <= GPTU_BASE_RST;
      sc1_r <= GPTU_SCALE_RST;
      sc2_r <= GPTU_SCALE_RST;
    end
    else
    begin
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      sc1_r <= sc1_nxt;
      sc2_r <= sc2_nxt;
    end
  end

  // Per timer clock selection, direction and wrap detection
  for (genvar i = 0; i < GPTU_NT; i++)
  begin : g_tmr
    logic [6:0] mask, sc;
    logic base, pre_tick, chain_evt, chained, stopped, raw_tick, incr_up;
    always_comb
    begin
      mask = 7'((8'h01 << PRESCALE[i]) - 8'h01);
      sc = (i < M1_COUNT) ? sc1_r : sc2_r;
      base = (i < M1_COUNT) ? b1_tick : b2_tick;
      pre_tick = base & ((sc & mask) == mask);
      pin_evt[i] = (EDGE_SEL[i][0] & cnt_rise[i]) | (EDGE_SEL[i][1] & cnt_fall[i]);
      chain_evt = 1'b0;
      chained = 1'b0;
      stopped = 1'b0;
      if (i == IX_AUX_A)
      begin
        chain_evt = ovf[IX_CORE];
        chained = CHAIN_LATCH[0];
        stopped = (AUX_FUNC[0] != AUXF_NORMAL);
      end
      if (i == IX_AUX_B)
      begin
        chain_evt = ovf[IX_CORE];
        chained = CHAIN_LATCH[1];
        stopped = (AUX_FUNC[1] != AUXF_NORMAL);
      end
      if (i == IX_SAUX)
      begin
        chain_evt = ovf[IX_SMAIN];
        chained = CHAIN_LATCH[2];
      end
      incr_up = s2_r.cnt[i] ^ s3_r.dir[i];
      down[i] = DIR_DOWN[i] ^ (DIR_PIN_EN[i] & s2_r.dir[i]);
      case (MODE[i])
        GPTU_TIMER: raw_tick = pre_tick;
        GPTU_GATED: raw_tick = pre_tick & s2_r.cnt[i];
        GPTU_COUNTER: raw_tick = chained ? chain_evt : pin_evt[i];
        GPTU_INCR:
        begin
          raw_tick = (i < M1_COUNT) & ((s2_r.cnt[i] ^ s3_r.cnt[i]) | (s2_r.dir[i] ^ s3_r.dir[i]));
          down[i] = DIR_DOWN[i] ^ ~incr_up;
        end
        default: raw_tick = 1'b0;
      endcase
      tick[i] = raw_tick & RUN[i] & ~stopped;
      ovf[i] = tick[i] & (down[i] ? (val_r[i] == GPTU_VAL_RST) : (val_r[i] == GPTU_VAL_MAX));
    end
    assign TIMER_VAL[i] = val_r[i];
  end

  // Capture and reload triggers of the auxiliary timers
  for (genvar a = 0; a < 2; a++)
  begin : g_aux
    logic trig;
    always_comb
    begin
      case (RELOAD_TRIG[a])
        RLD_PIN: trig = pin_evt[2 * a];
        RLD_LATCH_RISE: trig = ovf[IX_CORE] & ~core_latch_r;
        RLD_LATCH_FALL: trig = ovf[IX_CORE] & core_latch_r;
        default: trig = 1'b0;
      endcase
      cap_aux[a] = (AUX_FUNC[a] == AUXF_CAPTURE) & pin_evt[2 * a];
      rld_aux[a] = (AUX_FUNC[a] == AUXF_RELOAD) & trig;
    end
  end

  assign capreg_evt = (CAP_SRC[0] & ((CAP_EDGE[0] & cap_rise) | (CAP_EDGE[1] & cap_fall)))
    | (CAP_SRC[1] & (cnt_rise[IX_CORE] | cnt_fall[IX_CORE]))
    | (CAP_SRC[2] & (dir_rise[IX_CORE] | dir_fall[IX_CORE]));

  // Timer values, capture register, latches and flags
  always_comb
  begin
    for (int i = 0; i < GPTU_NT; i++)
    begin
      val_nxt[i] = val_r[i];
      if (tick[i])
        val_nxt[i] = down[i] ? val_r[i] - 16'h0001 : val_r[i] + 16'h0001;
    end
    if (cap_aux[0])
      val_nxt[IX_AUX_A] = val_r[IX_CORE];
    if (cap_aux[1])
      val_nxt[IX_AUX_B] = val_r[IX_CORE];
    if (rld_aux[0])
      val_nxt[IX_CORE] = val_r[IX_AUX_A];
    if (rld_aux[1])
      val_nxt[IX_CORE] = val_r[IX_AUX_B];
    capreg_nxt = capreg_r;
    if (capreg_evt)
    begin
      capreg_nxt = val_r[IX_SAUX];
      if (CAP_CLEAR)
        val_nxt[IX_SAUX] = GPTU_VAL_RST;
    end
    if (ovf[IX_SMAIN] & SEC_RELOAD_EN)
      val_nxt[IX_SMAIN] = capreg_r;
    for (int i = 0; i < GPTU_NT; i++)
    begin
      if (LOAD_EN[i])
        val_nxt[i] = LOAD_VAL;
    end
    if (CAPREG_LOAD)
      capreg_nxt = LOAD_VAL;
    core_latch_nxt = core_latch_r ^ ovf[IX_CORE];
    auxb_latch_nxt = auxb_latch_r ^ ovf[IX_AUX_B];
    smain_latch_nxt = smain_latch_r ^ ovf[IX_SMAIN];
    smain_ovf_nxt = ovf[IX_SMAIN];
    flags_nxt.ovf = (flags_r.ovf & ~FLAG_CLR[4:0]) | ovf;
    flags_nxt.cap = (flags_r.cap & ~FLAG_CLR[7:5]) | {capreg_evt, cap_aux};
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < GPTU_NT; i++)
        val_r[i] <= GPTU_VAL_RST;
      capreg_r <= GPTU_VAL_RST;
      core_latch_r <= 1'b0;
      auxb_latch_r <= 1'b0;
      smain_latch_r <= 1'b0;
      smain_ovf_r <= 1'b0;
      flags_r <= GPTU_FLAGS_RST;
    end
    else
    begin
      for (int i = 0; i < GPTU_NT; i++)
        val_r[i] <= val_nxt[i];
      capreg_r <= capreg_nxt;
      core_latch_r <= core_latch_nxt;
      auxb_latch_r <= auxb_latch_nxt;
      smain_latch_r <= smain_latch_nxt;
      smain_ovf_r <= smain_ovf_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign CAPREG_VAL = capreg_r;
  assign CORE_TOGGLE_OUT = core_latch_r;
  assign AUX_B_TOGGLE_OUT = auxb_latch_r;
  assign SEC_MAIN_TOGGLE_OUT = smain_latch_r;
  assign SEC_MAIN_OVF = smain_ovf_r;
  assign EVENT_FLAGS = flags_r;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_SYNC_LAG: assert property ((!$past(RST) && !$past(RST, 2)) |-> s2_r.cnt == $past(CNT_IN, 2))
    else $error("Count pin not seen two cycles later");
  AST_M1_RATE: assert property (b1_tick |=> !b1_tick [*7] ##1 b1_tick)
    else $error("First module base tick not every 8 cycles");
  AST_M2_RATE: assert property (b2_tick |=> !b2_tick [*3] ##1 b2_tick)
    else $error("Second module base tick not every 4 cycles");
  AST_GATE_LOW: assert property ((MODE[IX_CORE] == GPTU_GATED && !s2_r.cnt[IX_CORE])
    |-> !tick[IX_CORE])
    else $error("Gated core counted with gate closed");
  AST_CORE_STEP: assert property ((tick[IX_CORE] && !down[IX_CORE] && !rld_aux[0]
    && !rld_aux[1] && !LOAD_EN[IX_CORE]) |=> val_r[IX_CORE] == $past(val_r[IX_CORE]) + 16'h0001)
    else $error("Core did not count up by one");
  AST_CORE_LATCH: assert property (ovf[IX_CORE] |=> core_latch_r != $past(core_latch_r))
    else $error("Core latch did not toggle on wrap");
  AST_AUX_STOP: assert property ((AUX_FUNC[0] != AUXF_NORMAL && !cap_aux[0] && !LOAD_EN[IX_AUX_A])
    |=> $stable(val_r[IX_AUX_A]))
    else $error("Aux A moved while capture or reload");
  AST_AUX_CAP: assert property ((cap_aux[1] && !LOAD_EN[IX_AUX_B])
    |=> val_r[IX_AUX_B] == $past(val_r[IX_CORE]))
    else $error("Aux B did not capture core");
  AST_RELOAD: assert property ((rld_aux[0] && !rld_aux[1] && !LOAD_EN[IX_CORE])
    |=> val_r[IX_CORE] == $past(val_r[IX_AUX_A]))
    else $error("Core not reloaded from aux A");
  AST_SEC_RELOAD: assert property ((ovf[IX_SMAIN] && SEC_RELOAD_EN && !LOAD_EN[IX_SMAIN])
    |=> val_r[IX_SMAIN] == $past(capreg_r) && SEC_MAIN_OVF)
    else $error("Second main not reloaded on wrap");
  AST_CAP_CLEAR: assert property ((capreg_evt && CAP_CLEAR && !CAPREG_LOAD && !LOAD_EN[IX_SAUX])
    |=> CAPREG_VAL == $past(val_r[IX_SAUX]) && val_r[IX_SAUX] == GPTU_VAL_RST)
    else $error("Capture register or clear wrong");
  AST_FLAG_SET: assert property (ovf[IX_CORE] |=> EVENT_FLAGS.ovf[IX_CORE])
    else $error("Wrap flag not set");

endmodule

// ==== gptu_pin_model.sv ====
// Partner model driving the timer unit's external pins
`timescale 1ns/1ns
module gptu_pin_model
  import gptu_pkg::*;
(
  input wire logic clk,
  output gptu_pins_s pins,
  output logic index
);
  logic [10:0] p;
  int ph;
  assign pins = p;
  initial
  begin
    p = 11'h000;
    index = 1'b0;
    ph = 0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Bit b: count pins 0..4, direction pins 5..9, capture pin 10
  task automatic lvl(input int b, input logic v);
    p[b] = v;
    hold(3);
  endtask
  task automatic pulse(input int b);
    lvl(b, 1'b1);
    lvl(b, 1'b0);
  endtask
  // Quadrature tracks on the core pins
  task automatic enc(input int n, input bit back);
    repeat (n)
    begin
      ph = back ? (ph + 3) % 4 : (ph + 1) % 4;
      p[IX_CORE] = ph inside {1, 2};
      p[5 + IX_CORE] = ph >= 2;
      index = ph == 0;
      hold(3);
    end
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench for the general purpose timer unit
`timescale 1ns/1ns
module tb
  import gptu_pkg::*;
;
  logic clk, rst, sec_rld, capreg_load, cap_clear;
  logic core_tgl, auxb_tgl, smain_tgl, smain_ovf;
  logic [4:0] run, dir_down, dir_pin_en, load_en;
  logic [2:0] chain, cap_src;
  logic [1:0] cap_edge;
  logic [15:0] load_val, capreg;
  logic [7:0] flag_clr;
  gptu_mode_e mode [GPTU_NT];
  logic [2:0] presc [GPTU_NT];
  logic [1:0] edge_sel [GPTU_NT];
  logic [1:0] aux_func [2];
  logic [1:0] rld_trig [2];
  logic [15:0] tval [GPTU_NT];
  gptu_pins_s pins;
  gptu_flags_s flags;
  int n_mismatch, total_checks;

  gptu_pin_model u_pm (.clk(clk), .pins(pins), .index());

  gptu_top u_gptu_top (
    .CLK(clk), .RST(rst), .CNT_IN(pins.cnt), .DIR_IN(pins.dir),
    .CAPTURE_PIN(pins.cap), .MODE(mode), .PRESCALE(presc), .EDGE_SEL(edge_sel),
    .RUN(run), .DIR_DOWN(dir_down), .DIR_PIN_EN(dir_pin_en), .CHAIN_LATCH(chain),
    .AUX_FUNC(aux_func), .RELOAD_TRIG(rld_trig), .SEC_RELOAD_EN(sec_rld),
    .CAP_SRC(cap_src), .CAP_EDGE(cap_edge), .CAP_CLEAR(cap_clear),
    .LOAD_EN(load_en), .CAPREG_LOAD(capreg_load), .LOAD_VAL(load_val),
    .FLAG_CLR(flag_clr), .TIMER_VAL(tval), .CAPREG_VAL(capreg),
    .CORE_TOGGLE_OUT(core_tgl), .AUX_B_TOGGLE_OUT(auxb_tgl),
    .SEC_MAIN_TOGGLE_OUT(smain_tgl), .SEC_MAIN_OVF(smain_ovf), .EVENT_FLAGS(flags)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic restart;
    rst = 1'b1;
    foreach (mode[i])
    begin
      mode[i] = GPTU_TIMER;
      presc[i] = 3'h0;
      edge_sel[i] = 2'h1;
    end
    aux_func = '{2'h0, 2'h0};
    rld_trig = '{2'h0, 2'h0};
    {run, dir_down, dir_pin_en, load_en, chain, cap_src, cap_edge} = '0;
    {sec_rld, capreg_load, cap_clear, flag_clr, load_val} = '0;
    step(5);
    rst = 1'b0;
  endtask
  task automatic ld(input int i, input logic [15:0] v);
    load_val = v;
    load_en[i] = 1'b1;
    step();
    load_en = 5'h00;
  endtask
  // Interval between two value changes of a free running timer
  task automatic per(input int i, input int p, input int base);
    logic [15:0] v;
    int n;
    presc[i] = 3'(p);
    run[i] = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      v = tval[i];
      n = 0;
      while (tval[i] === v && n < 300)
      begin
        step();
        n++;
      end
    end
    chk("period", 16'(n), 16'(base << p));
    run[i] = 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial
  begin
    int n;
    logic [15:0] v, w;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'h02F38476));
    restart();
    chk("reset value", tval[IX_CORE], GPTU_VAL_RST);
    chk("reset flags", 16'(flags), 16'h0000);
    for (int p = 0; p < 3; p++)
    begin
      per(IX_CORE, p, 400 / 50);
      per(IX_AUX_A, p, 400 / 50);
      per(IX_SMAIN, p, 200 / 50);
    end
    restart();
    n = $urandom_range(3, 9);
    mode[IX_CORE] = GPTU_COUNTER;
    run[IX_CORE] = 1'b1;
    dir_down[IX_CORE] = 1'b1;
    dir_pin_en[IX_CORE] = 1'b1;
    u_pm.lvl(5 + IX_CORE, 1'b1);
    repeat (n) u_pm.pulse(IX_CORE);
    chk("counter", tval[IX_CORE], 16'(n));
    u_pm.lvl(5 + IX_CORE, 1'b0);
    restart();
    mode[IX_CORE] = GPTU_GATED;
    run[IX_CORE] = 1'b1;
    step(40);
    chk("gate closed", tval[IX_CORE], 16'h0000);
    u_pm.lvl(IX_CORE, 1'b1);
    step(77);
    u_pm.lvl(IX_CORE, 1'b0);
    chk("gate open", 16'(tval[IX_CORE] inside {[9:11]}), 16'h0001);
    restart();
    mode[IX_CORE] = GPTU_INCR;
    run[IX_CORE] = 1'b1;
    u_pm.enc(6, 1'b0);
    u_pm.enc(2, 1'b1);
    step(4);
    chk("encoder", tval[IX_CORE], 16'h0004);
    restart();
    v = 16'($urandom);
    w = 16'($urandom);
    ld(IX_CORE, v);
    aux_func[0] = AUXF_CAPTURE;
    run[IX_AUX_A] = 1'b1;
    u_pm.pulse(IX_AUX_A);
    step(20);
    chk("capture", tval[IX_AUX_A], v);
    chk("cap flag", 16'(flags.cap[0]), 16'h0001);
    flag_clr = 8'h20;
    step();
    flag_clr = 8'h00;
    step();
    chk("flag clear", 16'(flags.cap[0]), 16'h0000);
    aux_func[1] = AUXF_RELOAD;
    rld_trig[1] = RLD_PIN;
    ld(IX_AUX_B, w);
    u_pm.pulse(IX_AUX_B);
    chk("reload", tval[IX_CORE], w);
    ld(IX_SAUX, v);
    cap_src = 3'h1;
    cap_edge = 2'h1;
    cap_clear = 1'b1;
    u_pm.pulse(10);
    chk("capreg", capreg, v);
    chk("aux cleared", tval[IX_SAUX], 16'h0000);
    chk("capreg flag", 16'(flags.cap[2]), 16'h0001);
    cap_src = 3'h2;
    cap_clear = 1'b0;
    ld(IX_SAUX, w);
    u_pm.pulse(IX_CORE);
    chk("core pin capture", capreg, w);
    restart();
    load_val = v;
    capreg_load = 1'b1;
    step();
    capreg_load = 1'b0;
    ld(IX_SMAIN, 16'hFFFF);
    ld(IX_CORE, 16'hFFFF);
    sec_rld = 1'b1;
    run = 5'h12;
    n = 0;
    while (smain_ovf !== 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    chk("wrap pulse", 16'(smain_ovf), 16'h0001);
    chk("wrap reload", tval[IX_SMAIN], v);
    chk("second latch", 16'(smain_tgl), 16'h0001);
    step(10);
    chk("core latch", 16'(core_tgl), 16'h0001);
    chk("wrap flag", 16'(flags.ovf[IX_CORE]), 16'h0001);
    results();
  end
endmodule
